// file: logic/debug_serial_pin_function_select.sv
// pin function selector for the serial, timer and debug pins
`timescale 1ns/1ps
`default_nettype none
module debug_serial_pin_function_select (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // raw pin levels, index per package constants
  input wire logic [pin_select_pkg::PIN_COUNT-1:0] pins_i,
  // configuration
  input wire pin_select_pkg::serial_cfg_t serial1_mode_select_i,
  input wire pin_select_pkg::timer_cfg_t timer2_cfg_i,
  input wire pin_select_pkg::trace_cfg_t trace_cfg_i,
  input wire pin_select_pkg::port_cfg_t port_cfg_i,
  // debug mode requests from the wire protocol logic
  input wire logic swire_select_i,
  input wire logic jtag_select_i,
  // peripheral drive requests
  input wire logic serial1_twi_clock_low_i,
  input wire logic timer2_channel2_out_i,
  input wire logic jtag_data_out_i,
  input wire logic async_trace_out_i,
  input wire logic sync_trace_data_zero_i,
  input wire logic sync_trace_clock_i,
  input wire logic swire_clock_out_i,
  input wire logic swire_clock_oe_i,
  input wire logic swire_data_out_i,
  input wire logic swire_data_oe_i,
  input wire logic [pin_select_pkg::PAD_COUNT-1:0] gpio_out_i,
  input wire logic [pin_select_pkg::PAD_COUNT-1:0] gpio_oe_i,
  // pad controls
  output pin_select_pkg::pad_t [pin_select_pkg::PAD_COUNT-1:0] pads_o,
  // peripheral inputs
  output logic serial1_spi_master_in_o,
  output logic serial1_spi_slave_in_o,
  output logic serial1_twi_clock_o,
  output logic serial1_uart_receive_o,
  output logic timer2_channel2_in_o,
  output logic jtag_clock_in_o,
  output logic jtag_data_in_o,
  output logic jtag_mode_select_o,
  output logic swire_clock_in_o,
  output logic swire_data_in_o,
  output logic [pin_select_pkg::PAD_COUNT-1:0] gpio_in_o,
  // status
  output logic debug_swire_o
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [pin_select_pkg::PIN_COUNT-1:0] pin_meta_q;
  logic [pin_select_pkg::PIN_COUNT-1:0] pin_sync_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= pins_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------------
  // debug port mode
  // ---------------------------------------------------------------------
  pin_select_pkg::dbg_mode_t dbg_q;
  logic swire;

  // external reset pin low forces jtag, even over a wire mode request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dbg_q <= pin_select_pkg::DBG_JTAG; // see [RULE16]
    end else if (!pin_sync_q[pin_select_pkg::PIN_NRST]) begin
      dbg_q <= pin_select_pkg::DBG_JTAG; // see [RULE16]
    end else begin
      case (dbg_q)
        pin_select_pkg::DBG_JTAG: begin
          if (swire_select_i) begin
            dbg_q <= pin_select_pkg::DBG_SWIRE; // see [RULE16]
          end
        end
        pin_select_pkg::DBG_SWIRE: begin
          if (jtag_select_i) begin
            dbg_q <= pin_select_pkg::DBG_JTAG;
          end
        end
        default: begin
          dbg_q <= pin_select_pkg::DBG_JTAG;
        end
      endcase
    end
  end

  assign swire = (dbg_q == pin_select_pkg::DBG_SWIRE);

  // ---------------------------------------------------------------------
  // selection terms
  // ---------------------------------------------------------------------
  logic remap2;
  logic pb2_alt_out;
  logic pb2_alt_od;
  logic twi_sel;
  logic tim_out_sel;
  logic dbg_gpio;
  logic pc2_gpio;
  logic pc3_gpio;
  logic pc4_gpio;
  logic sync_data_sel;
  logic async_sel;
  logic trace_clk_sel;

  assign remap2 = timer2_cfg_i.remap_option[pin_select_pkg::REMAP_CH2_BIT];
  assign pb2_alt_out = port_cfg_i.portb_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  assign pb2_alt_od = port_cfg_i.portb_low[11:8] == pin_select_pkg::CFG_ALT_OD;
  // see [RULE3]
  assign twi_sel = (serial1_mode_select_i.mode == pin_select_pkg::SER_TWI) &&
                   pb2_alt_od && (!timer2_cfg_i.ch2_out_en || !remap2);
  // see [RULE5]
  assign tim_out_sel = remap2 && timer2_cfg_i.ch2_out_en && pb2_alt_out;
  assign dbg_gpio = port_cfg_i.debug_pin[pin_select_pkg::DBG_GPIO_BIT];
  // see [RULE8]
  assign pc2_gpio = dbg_gpio &&
                    !port_cfg_i.portc_high[pin_select_pkg::PCH_PC2_BIT];
  assign pc3_gpio = dbg_gpio || swire; // see [RULE12]
  assign pc4_gpio = dbg_gpio; // see [RULE15]
  // see [RULE11]
  assign sync_data_sel = trace_cfg_i.enable && !trace_cfg_i.async_sel &&
                         trace_cfg_i.sync_four_wire &&
                         port_cfg_i.porta_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  // see [RULE10]
  assign async_sel = trace_cfg_i.enable && trace_cfg_i.async_sel && swire &&
                     port_cfg_i.portc_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  // see [RULE14]
  assign trace_clk_sel = trace_cfg_i.enable && !trace_cfg_i.async_sel &&
                         port_cfg_i.portc_low[15:12] == pin_select_pkg::CFG_ALT_OUT;

  // ---------------------------------------------------------------------
  // pad drive
  // ---------------------------------------------------------------------
  pin_select_pkg::pad_t [pin_select_pkg::PAD_COUNT-1:0] pad_d;
  pin_select_pkg::pad_t [pin_select_pkg::PAD_COUNT-1:0] pad_q;

  // trace claims a debug pin ahead of its general i/o use, since the
  // trace unit is only enabled deliberately by the core
  always_comb begin
    pad_d = '0;
    // port b pin two
    if (twi_sel) begin
      pad_d[pin_select_pkg::PAD_PB2].out = 1'b0; // see [RULE3]
      pad_d[pin_select_pkg::PAD_PB2].oe = serial1_twi_clock_low_i;
    end else if (tim_out_sel) begin
      pad_d[pin_select_pkg::PAD_PB2].out = timer2_channel2_out_i; // see [RULE5]
      pad_d[pin_select_pkg::PAD_PB2].oe = 1'b1;
    end else begin
      pad_d[pin_select_pkg::PAD_PB2].out = gpio_out_i[pin_select_pkg::PAD_PB2];
      pad_d[pin_select_pkg::PAD_PB2].oe = gpio_oe_i[pin_select_pkg::PAD_PB2]; // see [RULE18]
    end
    // pin 32, debug clock
    if (swire) begin
      pad_d[pin_select_pkg::PAD_P32].out = swire_clock_out_i; // see [RULE7]
      pad_d[pin_select_pkg::PAD_P32].oe = swire_clock_oe_i;
    end else begin
      pad_d[pin_select_pkg::PAD_P32].pull_down = 1'b1; // see [RULE7]
    end
    // port c pin two
    if (sync_data_sel) begin
      pad_d[pin_select_pkg::PAD_PC2].out = sync_trace_data_zero_i; // see [RULE11]
      pad_d[pin_select_pkg::PAD_PC2].oe = 1'b1;
    end else if (async_sel) begin
      pad_d[pin_select_pkg::PAD_PC2].out = async_trace_out_i; // see [RULE10]
      pad_d[pin_select_pkg::PAD_PC2].oe = 1'b1;
      pad_d[pin_select_pkg::PAD_PC2].pull_up = 1'b1;
    end else if (pc2_gpio) begin
      pad_d[pin_select_pkg::PAD_PC2].out = gpio_out_i[pin_select_pkg::PAD_PC2]; // see [RULE8]
      pad_d[pin_select_pkg::PAD_PC2].oe = gpio_oe_i[pin_select_pkg::PAD_PC2];
    end else if (!swire) begin
      pad_d[pin_select_pkg::PAD_PC2].out = jtag_data_out_i; // see [RULE9]
      pad_d[pin_select_pkg::PAD_PC2].oe = 1'b1;
    end
    // port c pin three
    if (trace_clk_sel) begin
      pad_d[pin_select_pkg::PAD_PC3].out = sync_trace_clock_i; // see [RULE14]
      pad_d[pin_select_pkg::PAD_PC3].oe = 1'b1;
    end else if (pc3_gpio) begin
      pad_d[pin_select_pkg::PAD_PC3].out = gpio_out_i[pin_select_pkg::PAD_PC3]; // see [RULE12]
      pad_d[pin_select_pkg::PAD_PC3].oe = gpio_oe_i[pin_select_pkg::PAD_PC3];
    end else begin
      pad_d[pin_select_pkg::PAD_PC3].pull_up = 1'b1; // see [RULE13]
    end
    // pin 35, port c pin four
    if (pc4_gpio) begin
      pad_d[pin_select_pkg::PAD_PC4].out = gpio_out_i[pin_select_pkg::PAD_PC4]; // see [RULE15]
      pad_d[pin_select_pkg::PAD_PC4].oe = gpio_oe_i[pin_select_pkg::PAD_PC4];
    end else if (swire) begin
      pad_d[pin_select_pkg::PAD_PC4].out = swire_data_out_i; // see [RULE17]
      pad_d[pin_select_pkg::PAD_PC4].oe = swire_data_oe_i;
      pad_d[pin_select_pkg::PAD_PC4].pull_up = 1'b1;
    end else begin
      pad_d[pin_select_pkg::PAD_PC4].pull_up = 1'b1; // see [RULE17]
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pads_o = pad_q;
  assign debug_swire_o = swire;

  // ---------------------------------------------------------------------
  // input routing
  // ---------------------------------------------------------------------
  logic pb2_in;
  logic spi_mode;

  assign pb2_in = pin_sync_q[pin_select_pkg::PAD_PB2];
  assign spi_mode = serial1_mode_select_i.mode == pin_select_pkg::SER_SPI;

  // unselected serial inputs rest at the idle level so a stray pin
  // toggle cannot look like traffic to the controller
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      serial1_spi_master_in_o <= pin_select_pkg::IDLE_IN;
      serial1_spi_slave_in_o <= pin_select_pkg::IDLE_IN;
      serial1_twi_clock_o <= pin_select_pkg::IDLE_IN;
      serial1_uart_receive_o <= pin_select_pkg::IDLE_IN;
      timer2_channel2_in_o <= 1'b0;
    end else begin
      serial1_spi_master_in_o <= (spi_mode && serial1_mode_select_i.master) ?
                                 pb2_in : pin_select_pkg::IDLE_IN; // see [RULE1]
      serial1_spi_slave_in_o <= (spi_mode && !serial1_mode_select_i.master) ?
                                pb2_in : pin_select_pkg::IDLE_IN; // see [RULE2]
      serial1_twi_clock_o <= twi_sel ? pb2_in : pin_select_pkg::IDLE_IN; // see [RULE3]
      serial1_uart_receive_o <=
        (serial1_mode_select_i.mode == pin_select_pkg::SER_UART) ?
        pb2_in : pin_select_pkg::IDLE_IN; // see [RULE4]
      timer2_channel2_in_o <= remap2 ? pb2_in : 1'b0; // see [RULE6]
    end
  end

  // jtag side inputs rest as their pulls would leave them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      jtag_clock_in_o <= 1'b0;
      jtag_data_in_o <= 1'b1;
      jtag_mode_select_o <= 1'b1;
      swire_clock_in_o <= 1'b0;
      swire_data_in_o <= 1'b1;
      gpio_in_o <= '0;
    end else begin
      jtag_clock_in_o <= swire ? 1'b0 :
                         pin_sync_q[pin_select_pkg::PAD_P32]; // see [RULE7]
      jtag_data_in_o <= (swire || pc3_gpio) ? 1'b1 :
                        pin_sync_q[pin_select_pkg::PAD_PC3]; // see [RULE13]
      jtag_mode_select_o <= (swire || pc4_gpio) ? 1'b1 :
                            pin_sync_q[pin_select_pkg::PAD_PC4]; // see [RULE17]
      swire_clock_in_o <= swire ? pin_sync_q[pin_select_pkg::PAD_P32] : 1'b0;
      swire_data_in_o <= (swire && !pc4_gpio) ?
                         pin_sync_q[pin_select_pkg::PAD_PC4] : 1'b1;
      gpio_in_o <= pin_sync_q[pin_select_pkg::PAD_COUNT-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_jtag_after_reset: assert property ( // see [RULE16]
    $fell(sys_rst_i) |-> !debug_swire_o ##1 pads_o[1].pull_down)
    else $error("debug mode not jtag after reset");
  a_ext_reset_jtag: assert property ( // see [RULE16]
    !pin_sync_q[pin_select_pkg::PIN_NRST] |=> !debug_swire_o)
    else $error("external reset did not force jtag");
  a_swire_entry: assert property ( // see [RULE16]
    !swire && swire_select_i && pin_sync_q[pin_select_pkg::PIN_NRST]
    |=> swire ##1 !pads_o[1].pull_down)
    else $error("wire mode request ignored");
  a_twi_open_drain: assert property ( // see [RULE3]
    twi_sel |=> !pads_o[0].out && pads_o[0].oe == $past(serial1_twi_clock_low_i))
    else $error("twi clock not open drain");
  a_timer_drive: assert property ( // see [RULE5]
    tim_out_sel && !twi_sel |=> pads_o[0].oe &&
    pads_o[0].out == $past(timer2_channel2_out_i))
    else $error("timer output not on pin");
  a_spi_master_in: assert property ( // see [RULE1]
    spi_mode && serial1_mode_select_i.master |=>
    serial1_spi_master_in_o == $past(pb2_in) && serial1_spi_slave_in_o)
    else $error("spi master input misrouted");
  a_uart_receive: assert property ( // see [RULE4]
    serial1_mode_select_i.mode == pin_select_pkg::SER_UART |=>
    serial1_uart_receive_o == $past(pb2_in))
    else $error("uart receive misrouted");
  a_tdo_drive: assert property ( // see [RULE9]
    !swire && !sync_data_sel && !pc2_gpio |=> pads_o[2].oe &&
    pads_o[2].out == $past(jtag_data_out_i))
    else $error("jtag data out not driven");
  a_tdi_pullup: assert property ( // see [RULE13]
    !swire && !pc3_gpio && !trace_clk_sel |=>
    pads_o[3].pull_up && !pads_o[3].oe)
    else $error("jtag data in pin not pulled up");
  a_pc4_pullup: assert property ( // see [RULE17]
    !pc4_gpio |=> pads_o[4].pull_up)
    else $error("mode select pin not pulled up");
  a_async_pullup: assert property ( // see [RULE10]
    async_sel && !sync_data_sel |=> pads_o[2].pull_up && pads_o[2].oe)
    else $error("async trace not driven with pull up");
  a_spi_slave_in: assert property ( // see [RULE2]
    spi_mode && !serial1_mode_select_i.master |=>
    serial1_spi_slave_in_o == $past(pb2_in) && serial1_spi_master_in_o)
    else $error("spi slave input misrouted");
  a_twi_clock_in: assert property ( // see [RULE3]
    twi_sel |=> serial1_twi_clock_o == $past(pb2_in))
    else $error("twi clock input misrouted");
  a_timer_in: assert property ( // see [RULE6]
    remap2 |=> timer2_channel2_in_o == $past(pb2_in))
    else $error("timer input misrouted");
  a_pb2_fallback: assert property ( // see [RULE18]
    !twi_sel && !tim_out_sel |=>
    pads_o[0].oe == $past(gpio_oe_i[pin_select_pkg::PAD_PB2]))
    else $error("pin b2 not on general i/o");
  a_pc2_gpio: assert property ( // see [RULE8]
    pc2_gpio && !sync_data_sel && !async_sel |=>
    pads_o[2].oe == $past(gpio_oe_i[pin_select_pkg::PAD_PC2]))
    else $error("pin c2 general i/o not driven");
  a_sync_trace: assert property ( // see [RULE11]
    sync_data_sel |=> pads_o[2].oe &&
    pads_o[2].out == $past(sync_trace_data_zero_i))
    else $error("sync trace data not on pin");
  a_trace_clock: assert property ( // see [RULE14]
    trace_clk_sel |=> pads_o[3].oe &&
    pads_o[3].out == $past(sync_trace_clock_i))
    else $error("trace clock not on pin");
  a_wire_clock: assert property ( // see [RULE7]
    swire |=> !pads_o[1].pull_down &&
    pads_o[1].oe == $past(swire_clock_oe_i))
    else $error("wire clock pad wrong");

  c_twi_clock: cover property (twi_sel ##1 pads_o[0].oe);
  c_timer_out: cover property (tim_out_sel ##1 pads_o[0].oe);
  c_wire_mode: cover property (!swire ##1 swire ##1 pads_o[4].oe);
  c_async_trace: cover property (async_sel ##1 pads_o[2].pull_up);
  c_sync_trace: cover property (sync_data_sel ##1 pads_o[2].oe);

endmodule
`default_nettype wire

// file: include/pin_select_pkg.sv
// shared types and constants for the debug and serial pin selector
// ---------------------------------------------------------------------
// What this block does
// [RULE1] pin b2 feeds spi master input when master
// [RULE2] pin b2 feeds spi slave input when slave
// [RULE3] pin b2 drives open-drain twi clock when allowed
// [RULE4] pin b2 feeds uart receive in uart mode
// [RULE5] timer channel two drives b2 when fully enabled
// [RULE6] timer channel two input from b2 when remapped
// [RULE7] pin 32: wire clock, or pulled-down jtag clock
// [RULE8] c2 general i/o needs debug bit, no high bit
// [RULE9] c2 drives jtag data out in jtag mode
// [RULE10] c2 drives pulled-up async trace in wire mode
// [RULE11] c2 drives sync trace data when selected
// [RULE12] c3 is general i/o: debug bit or wire
// [RULE13] c3 takes pulled-up jtag data in, jtag mode
// [RULE14] c3 drives sync trace clock when selected
// [RULE15] c4 general i/o only with debug bit
// [RULE16] jtag mode after reset; debugger requests wire mode
// [RULE17] pin 35 pulled-up mode select or wire data
// [RULE18] unclaimed pin b2 falls back to general i/o
// ---------------------------------------------------------------------
package pin_select_pkg;

  // ---------------------------------------------------------------------
  // pad indices
  // ---------------------------------------------------------------------
  localparam int PAD_COUNT = 5;
  localparam int PAD_PB2 = 0;
  localparam int PAD_P32 = 1;
  localparam int PAD_PC2 = 2;
  localparam int PAD_PC3 = 3;
  localparam int PAD_PC4 = 4;
  localparam int PIN_COUNT = 6;
  localparam int PIN_NRST = 5;

  // ---------------------------------------------------------------------
  // serial controller modes and port field encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] SER_OFF = 2'h0;
  localparam logic [1:0] SER_UART = 2'h1;
  localparam logic [1:0] SER_SPI = 2'h2;
  localparam logic [1:0] SER_TWI = 2'h3;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hD;
  localparam int REMAP_CH2_BIT = 5;
  localparam int DBG_GPIO_BIT = 5;
  localparam int PCH_PC2_BIT = 1;
  localparam logic IDLE_IN = 1'b1;

  typedef enum logic {DBG_JTAG, DBG_SWIRE} dbg_mode_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
  } pad_t;

  typedef struct packed {
    logic [1:0] mode;
    logic master;
  } serial_cfg_t;

  typedef struct packed {
    logic [7:0] remap_option;
    logic ch2_out_en;
  } timer_cfg_t;

  typedef struct packed {
    logic enable;
    logic async_sel;
    logic sync_four_wire;
  } trace_cfg_t;

  typedef struct packed {
    logic [15:0] porta_low;
    logic [15:0] portb_low;
    logic [15:0] portc_low;
    logic [15:0] portc_high;
    logic [7:0] debug_pin;
  } port_cfg_t;

endpackage

// file: dv/pin_peer_model.sv
// behavioural model of the debugger and serial peers at the five pins
`timescale 1ns/1ps
`default_nettype none
module pin_peer_model (
  // clock
  input wire logic clk_i,
  // pad controls from the selector and what the far side drives
  input wire pin_select_pkg::pad_t [4:0] pads_i,
  input wire logic [4:0] peer_out_i,
  input wire logic [4:0] peer_oe_i,
  input wire logic reset_level_i,
  // resolved wire levels
  output logic [5:0] pins_o
);
  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  logic [4:0] float_q = '0;

  // an undriven line flips each cycle so a stale level never reads as data
  always @(posedge clk_i) float_q <= ~pins_o[4:0];

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pads_i[i].oe) pins_o[i] = pads_i[i].out;
      else if (peer_oe_i[i]) pins_o[i] = peer_out_i[i];
      else if (pads_i[i].pull_up) pins_o[i] = 1'b1;
      else if (pads_i[i].pull_down) pins_o[i] = 1'b0;
      else pins_o[i] = float_q[i];
    end
    pins_o[5] = reset_level_i;
  end
endmodule
`default_nettype wire

// file: dv/debug_serial_pin_function_select_test.sv
// self-checking testbench for the debug and serial pin selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module debug_serial_pin_function_select_test;
  // ---------------------------------------------------------------
  // stimulus and design hookup
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  int mismatches = 0, n_compared = 0, cyc = 0;
  logic [31:0] seed = 32'h8C6A;
  logic [5:0] pins;
  pin_select_pkg::serial_cfg_t ser = '0;
  pin_select_pkg::timer_cfg_t tim = '0;
  pin_select_pkg::trace_cfg_t trc = '0;
  pin_select_pkg::port_cfg_t pcfg = '0;
  logic sws = 1'b0, jts = 1'b0, rpin = 1'b1;
  logic [9:0] drv = '0;
  logic [4:0] go = '0, goe = '0, peer_out = '0, peer_oe = '0;
  pin_select_pkg::pad_t [4:0] pads;
  logic smi, ssi, twc, urx, t2i, jci, jdi, jms, sci, sdi, dsw;
  logic [4:0] gin;

  always #20 clk_i = ~clk_i;

  debug_serial_pin_function_select DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
    .serial1_mode_select_i(ser), .timer2_cfg_i(tim), .trace_cfg_i(trc),
    .port_cfg_i(pcfg), .swire_select_i(sws), .jtag_select_i(jts),
    .serial1_twi_clock_low_i(drv[9]), .timer2_channel2_out_i(drv[8]),
    .jtag_data_out_i(drv[7]), .async_trace_out_i(drv[6]),
    .sync_trace_data_zero_i(drv[5]), .sync_trace_clock_i(drv[4]),
    .swire_clock_out_i(drv[3]), .swire_clock_oe_i(drv[2]),
    .swire_data_out_i(drv[1]), .swire_data_oe_i(drv[0]),
    .gpio_out_i(go), .gpio_oe_i(goe), .pads_o(pads),
    .serial1_spi_master_in_o(smi), .serial1_spi_slave_in_o(ssi),
    .serial1_twi_clock_o(twc), .serial1_uart_receive_o(urx),
    .timer2_channel2_in_o(t2i), .jtag_clock_in_o(jci),
    .jtag_data_in_o(jdi), .jtag_mode_select_o(jms),
    .swire_clock_in_o(sci), .swire_data_in_o(sdi), .gpio_in_o(gin),
    .debug_swire_o(dsw));

  pin_peer_model peer (.clk_i(clk_i), .pads_i(pads), .peer_out_i(peer_out),
    .peer_oe_i(peer_oe), .reset_level_i(rpin), .pins_o(pins));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  logic [5:0] s1_q, s2_q;
  logic wire_q;
  pin_select_pkg::pad_t [4:0] e_pads_q;
  logic [4:0] e_ser_q;
  logic [4:0] e_dbg_q, e_gin_q;
  logic dbg5, spi, tw, tm, sy, as_on, tc;

  assign dbg5 = pcfg.debug_pin[pin_select_pkg::DBG_GPIO_BIT];
  assign spi = ser.mode == pin_select_pkg::SER_SPI;
  assign tw = ser.mode == pin_select_pkg::SER_TWI &&
    pcfg.portb_low[11:8] == pin_select_pkg::CFG_ALT_OD &&
    !(tim.ch2_out_en && tim.remap_option[5]);
  assign tm = tim.remap_option[5] && tim.ch2_out_en &&
    pcfg.portb_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  assign sy = trc.enable && !trc.async_sel && trc.sync_four_wire &&
    pcfg.porta_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  assign as_on = trc.enable && trc.async_sel && wire_q &&
    pcfg.portc_low[11:8] == pin_select_pkg::CFG_ALT_OUT;
  assign tc = trc.enable && !trc.async_sel &&
    pcfg.portc_low[15:12] == pin_select_pkg::CFG_ALT_OUT;

  function automatic pin_select_pkg::pad_t pad_model(input int i);
    pin_select_pkg::pad_t p;
    p = '0;
    case (i)
      0: begin
        if (tw) p.oe = drv[9];
        else if (tm) {p.oe, p.out} = {1'b1, drv[8]};
        else {p.oe, p.out} = {goe[0], go[0]};
      end
      1: begin
        if (wire_q) {p.oe, p.out} = {drv[2], drv[3]};
        else p.pull_down = 1'b1;
      end
      2: begin
        if (sy) {p.oe, p.out} = {1'b1, drv[5]};
        else if (as_on) {p.oe, p.out, p.pull_up} = {1'b1, drv[6], 1'b1};
        else if (dbg5 && !pcfg.portc_high[1]) {p.oe, p.out} = {goe[2], go[2]};
        else if (!wire_q) {p.oe, p.out} = {1'b1, drv[7]};
      end
      3: begin
        if (tc) {p.oe, p.out} = {1'b1, drv[4]};
        else if (dbg5 || wire_q) {p.oe, p.out} = {goe[3], go[3]};
        else p.pull_up = 1'b1;
      end
      default: begin
        if (dbg5) {p.oe, p.out} = {goe[4], go[4]};
        else if (wire_q) {p.oe, p.out, p.pull_up} = {drv[0], drv[1], 1'b1};
        else p.pull_up = 1'b1;
      end
    endcase
    return p;
  endfunction

  // the level on an undriven pad does not matter, so out is masked by oe
  function automatic pin_select_pkg::pad_t msk(input pin_select_pkg::pad_t p);
    msk = p;
    msk.out = p.out & p.oe;
  endfunction

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= '1;
      s2_q <= '1;
      wire_q <= 1'b0;
      e_pads_q <= '0;
      e_ser_q <= 5'h1E;
      e_dbg_q <= 5'h0D;
      e_gin_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      if (!s2_q[5]) wire_q <= 1'b0;
      else if (wire_q) wire_q <= !jts;
      else wire_q <= sws;
      for (int i = 0; i < 5; i++) e_pads_q[i] <= pad_model(i);
      e_ser_q <= {spi && ser.master ? s2_q[0] : 1'b1,
        spi && !ser.master ? s2_q[0] : 1'b1,
        tw ? s2_q[0] : 1'b1,
        ser.mode == pin_select_pkg::SER_UART ? s2_q[0] : 1'b1,
        tim.remap_option[5] & s2_q[0]};
      e_dbg_q <= {!wire_q & s2_q[1], wire_q | dbg5 | s2_q[3],
        wire_q | dbg5 | s2_q[4], wire_q & s2_q[1], !wire_q | dbg5 | s2_q[4]};
      e_gin_q <= s2_q[4:0];
    end
  end

  always @(negedge clk_i) begin
    `CHK("pad b2", msk(e_pads_q[0]),
      msk(pads[0]))
    `CHK("pad debug clock", msk(e_pads_q[1]), msk(pads[1]))
    `CHK("pad c2", msk(e_pads_q[2]),
      msk(pads[2]))
    `CHK("pad c3", msk(e_pads_q[3]),
      msk(pads[3]))
    `CHK("pad c4", msk(e_pads_q[4]), msk(pads[4]))
    `CHK("serial in", e_ser_q,
      {smi, ssi, twc, urx, t2i})
    `CHK("debug in", e_dbg_q,
      {jci, jdi, jms, sci, sdi})
    `CHK("debug mode", wire_q, dsw)
    `CHK("gpio in", e_gin_q, gin)
  end

  // ---------------------------------------------------------------
  // random stimulus and run control
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 32; k++) begin
      s = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    end
    return s;
  endfunction

  // bias port fields towards the two alternate encodings
  function automatic logic [3:0] fld(input logic [5:0] r);
    if (r[5:4] == 2'h0) return pin_select_pkg::CFG_ALT_OUT;
    if (r[5:4] == 2'h1) return pin_select_pkg::CFG_ALT_OD;
    return r[3:0];
  endfunction

  task automatic drive_random();
    logic [31:0] a, b, c;
    pin_select_pkg::port_cfg_t p;
    a = lfsr(seed);
    b = lfsr(a);
    c = lfsr(b);
    seed = c;
    p = pin_select_pkg::port_cfg_t'({a, b, c[31:24]});
    p.porta_low[11:8] = fld(a[5:0]);
    p.portb_low[11:8] = fld(a[11:6]);
    p.portc_low[11:8] = fld(a[17:12]);
    p.portc_low[15:12] = fld(a[23:18]);
    pcfg <= p;
    ser <= pin_select_pkg::serial_cfg_t'(b[2:0]);
    tim <= pin_select_pkg::timer_cfg_t'(b[11:3]);
    trc <= pin_select_pkg::trace_cfg_t'(b[14:12]);
    drv <= c[9:0];
    go <= c[14:10];
    goe <= c[19:15];
    peer_out <= b[19:15];
    peer_oe <= b[24:20];
    rpin <= c[23:20] != 4'h0;
    sws <= c[24];
    jts <= c[25] & c[26];
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int k = 0; k < 4000; k++) begin
      @(posedge clk_i);
      drive_random();
      if (k == 2000) sys_rst_i <= 1'b1;
      if (k == 2004) sys_rst_i <= 1'b0;
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
